// ==== hw/amp_strap_map.svh ====
// constants for the strap and sleep control logic of the amplifier
`ifndef AMP_STRAP_MAP_SVH
`define AMP_STRAP_MAP_SVH

// clock period of mclk and the sleep ramp time
`define CLK_PERIOD_NS 40
`define RAMP_TIME_NS 10000
`define RAMP_CYCLES (`RAMP_TIME_NS / `CLK_PERIOD_NS)

// gain strap codes
`define GAIN_CODE_19P2 2'h0
`define GAIN_CODE_22P6 2'h1
`define GAIN_CODE_25 2'h2
`define GAIN_CODE_SOFTWARE 2'h3

// digital path settings forced under strap control
`define BOOST_CODE_6DB 2'h1
`define VOLUME_CODE_0DB 8'hcf

// strap levels and reset values
`define PARALLELED_MONO_BRIDGE_STRAP_LEVEL 1'b1
`define RATE8_STRAP_LEVEL 1'b1
`define RESET_GAIN_STRAP 2'h0
`define RESET_DRIVE_LEVEL 8'h00

`endif

// ==== hw/amp_strap_pkg.sv ====
// types for the strap and sleep control logic of the amplifier
package amp_strap_pkg;

  typedef enum logic [1:0] {
    AGAIN_19P2 = 2'h0,
    AGAIN_22P6 = 2'h1,
    AGAIN_25 = 2'h2
  } analog_gain_type;

  typedef struct packed {
    analog_gain_type analog_gain;
    logic [1:0] boost;
    logic [7:0] volume;
  } gain_cfg_type;

  typedef struct packed {
    logic paralleled_mono_bridge;
    logic right_channel_source;
    logic rate_16x;
  } out_cfg_type;

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_RAMP_UP = 4'h2,
    ST_ON = 4'h4,
    ST_RAMP_DOWN = 4'h8
  } ramp_state_type;

endpackage : amp_strap_pkg

// ==== hw/output_ramp.sv ====
// graceful start and stop of the output stage switching
`timescale 1ns/1ps
`include "amp_strap_map.svh"
module output_ramp
  import amp_strap_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // requests
  input wire logic run,
  input wire logic stop_now,
  // output stage
  output logic switching_en,
  output logic output_hiz,
  output logic [7:0] drive_level
);

  localparam logic [7:0] LEVEL_MAX = 8'(`RAMP_CYCLES);

  ramp_state_type state_reg;
  ramp_state_type state_next;
  logic [7:0] level_reg;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF:
        if (run)
          state_next = ST_RAMP_UP;
      ST_RAMP_UP:
        if (!run)
          state_next = ST_RAMP_DOWN;
        else if (level_reg == LEVEL_MAX)
          state_next = ST_ON;
      ST_ON:
        if (!run)
          state_next = ST_RAMP_DOWN;
      ST_RAMP_DOWN:
        if (run)
          state_next = ST_RAMP_UP;
        else if (level_reg == 8'h00)
          state_next = ST_OFF;
      default:
        state_next = ST_OFF;
    endcase
    // shutdown drops the stage at once; an artifact is accepted there
    if (stop_now)
      state_next = ST_OFF;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      state_reg <= ST_OFF;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n || stop_now)
      level_reg <= `RESET_DRIVE_LEVEL;
    else if (state_reg == ST_RAMP_UP && level_reg != LEVEL_MAX)
      level_reg <= level_reg + 8'h01;
    else if (state_reg == ST_RAMP_DOWN && level_reg != 8'h00)
      level_reg <= level_reg - 8'h01; // R1
  end

  assign switching_en = (state_reg != ST_OFF); // R3
  assign output_hiz = (state_reg == ST_OFF); // R1
  assign drive_level = level_reg;

endmodule : output_ramp

// ==== hw/amp_strap_control.sv ====
// strap decode, control mode select, pin sharing and sleep of the amplifier
`timescale 1ns/1ps
`include "amp_strap_map.svh"
// Notes on behaviour
// R1 - strap mode sleep pin high ramps output stage gracefully to non-switching high-z
// R2 - signal path keeps running while asleep for a fast restart
// R3 - sleep stops output switching, unlike balanced mute which keeps switching
// R4 - controller should assert sleep before stopping audio or supplies
// R5 - gain straps 00, 01, 10 select 19.2, 22.6, 25 dBV analog gain
// R6 - digital boost stays at plus six decibels for every strap gain
// R7 - strap mode volume stays at unity and never changes
// R8 - gain straps 11 select software mode, gain taken from the i2c port
// R9 - software mode turns bridge strap into i2c clock, rate strap into data
// R10 - gain straps are captured once after reset and then held
// R11 - shutdown pin low enters shutdown in both modes, high leaves it
// R12 - strap mode rate pin low gives 16x, high gives 8x sample rate
// R13 - strap mode bridge pin high gives paralleled mono, low stereo bridge
// R14 - paralleled mono under strap control takes the right channel
module amp_strap_control
  import amp_strap_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // board straps and control pins
  input wire logic [1:0] gain_strap_pins,
  input wire logic sleep_or_address_strap,
  input wire logic amp_shutdown_n,
  input wire logic bridge_mode_or_i2c_clock,
  // shared rate strap and i2c data pin
  input wire logic switch_rate_or_i2c_data_in,
  output logic switch_rate_or_i2c_data_out,
  output logic switch_rate_or_i2c_data_oe,
  // i2c control port side
  output logic i2c_enable,
  output logic i2c_scl_in,
  output logic i2c_sda_in,
  input wire logic i2c_sda_pull_low,
  input wire gain_cfg_type sw_gain_cfg,
  input wire out_cfg_type sw_out_cfg,
  input wire logic sw_sleep,
  input wire logic sw_balanced_mute,
  // settings to the audio path
  output gain_cfg_type gain_cfg,
  output out_cfg_type out_cfg,
  output logic software_mode,
  output logic balanced_mute,
  // power state
  output logic shutdown_active,
  output logic signal_path_en,
  output logic sleep_active,
  // output stage
  output logic switching_en,
  output logic output_hiz,
  output logic [7:0] drive_level
);

  function automatic gain_cfg_type decode_gain(input logic [1:0] code);
    gain_cfg_type cfg;
    cfg.boost = `BOOST_CODE_6DB; // R6
    cfg.volume = `VOLUME_CODE_0DB; // R7
    case (code)
      `GAIN_CODE_22P6: cfg.analog_gain = AGAIN_22P6; // R5
      `GAIN_CODE_25: cfg.analog_gain = AGAIN_25; // R5
      default: cfg.analog_gain = AGAIN_19P2; // R5
    endcase
    return cfg;
  endfunction : decode_gain

  // lines handed to the i2c port rest high while the straps own the pins
  function automatic logic shared_pin(input logic sw_mode, input logic pin);
    return sw_mode ? pin : 1'b1;
  endfunction : shared_pin

  logic captured_reg;
  logic [1:0] gain_strap_reg;
  logic software_mode_reg;
  logic sleep_reg;
  logic shutdown_reg;
  gain_cfg_type gain_cfg_reg;
  out_cfg_type out_cfg_reg;
  out_cfg_type hw_out_cfg;
  gain_cfg_type hw_gain_cfg;
  logic sleep_request;
  logic mute_reg;
  logic run_stage;

  // straps are caught on the first edge after reset release, never under reset
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      captured_reg <= 1'b0;
    else
      captured_reg <= 1'b1;
  end

  // later strap changes are ignored so the mode cannot flip mid-stream
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      gain_strap_reg <= `RESET_GAIN_STRAP;
    else if (!captured_reg)
      gain_strap_reg <= gain_strap_pins; // R10
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      software_mode_reg <= 1'b0;
    else if (!captured_reg)
      software_mode_reg <= (gain_strap_pins == `GAIN_CODE_SOFTWARE); // R8 R10
  end

  // pin sharing: the i2c port sees idle-high lines in strap mode
  always_comb
  begin
    i2c_enable = software_mode_reg; // R9
    i2c_scl_in = shared_pin(software_mode_reg, bridge_mode_or_i2c_clock); // R9
    i2c_sda_in = shared_pin(software_mode_reg, switch_rate_or_i2c_data_in); // R9
    // open drain: the pin is only pulled low, never driven high
    switch_rate_or_i2c_data_out = 1'b0;
    switch_rate_or_i2c_data_oe = software_mode_reg & i2c_sda_pull_low; // R9
  end

  // strap mode output configuration
  // rate and bridge straps are read live; only the gain straps are latched
  always_comb
  begin
    hw_out_cfg.paralleled_mono_bridge =
      (bridge_mode_or_i2c_clock == `PARALLELED_MONO_BRIDGE_STRAP_LEVEL); // R13
    hw_out_cfg.right_channel_source = hw_out_cfg.paralleled_mono_bridge; // R14
    hw_out_cfg.rate_16x = (switch_rate_or_i2c_data_in != `RATE8_STRAP_LEVEL); // R12
  end

  // strap mode gain settings, fixed once the straps are caught
  always_comb
  begin
    hw_gain_cfg = decode_gain(gain_strap_reg); // R5 R6 R7
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      gain_cfg_reg <= decode_gain(`RESET_GAIN_STRAP);
    else if (software_mode_reg)
      gain_cfg_reg <= sw_gain_cfg; // R8
    else
      gain_cfg_reg <= hw_gain_cfg; // R5 R6 R7
  end

  // in software mode the shared pins carry i2c, so they cannot steer the stage
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      out_cfg_reg <= '0;
    else if (software_mode_reg)
      out_cfg_reg <= sw_out_cfg; // R9
    else
      out_cfg_reg <= hw_out_cfg; // R12 R13 R14
  end

  // shutdown pin is honoured in both control modes
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      shutdown_reg <= 1'b1;
    else
      shutdown_reg <= !amp_shutdown_n; // R11
  end

  // the sleep pin doubles as an address strap in software mode
  always_comb
  begin
    if (software_mode_reg)
      sleep_request = sw_sleep;
    else
      sleep_request = sleep_or_address_strap; // R1
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      sleep_reg <= 1'b0;
    else
      sleep_reg <= sleep_request;
  end

  // balanced mute silences the output but leaves the stage switching
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      mute_reg <= 1'b0;
    else
      mute_reg <= software_mode_reg & sw_balanced_mute; // R3
  end

  // controller is expected to sleep first so the ramp finishes cleanly (R4)
  // an early shutdown still stops the stage, at the cost of a click
  assign run_stage = captured_reg & !sleep_reg & !shutdown_reg; // R1 R3

  // one ramp serves sleep and wake; shutdown bypasses it through stop_now
  output_ramp output_ramp_inst (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(run_stage),
    .stop_now(shutdown_reg), // R11
    .switching_en(switching_en),
    .output_hiz(output_hiz),
    .drive_level(drive_level)
  );

  assign gain_cfg = gain_cfg_reg;
  assign out_cfg = out_cfg_reg;
  assign software_mode = software_mode_reg;
  assign balanced_mute = mute_reg;

  // the signal path stays up through sleep so that wake is quick
  assign shutdown_active = shutdown_reg;
  assign signal_path_en = !shutdown_reg; // R2
  assign sleep_active = sleep_reg & !shutdown_reg;

endmodule : amp_strap_control

// ==== tb/amp_strap_checker.sv ====
// concurrent checks on the strap and sleep control ports
`timescale 1ns/1ps
`include "amp_strap_map.svh"
module amp_strap_checker
  import amp_strap_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pins
  input wire logic sleep_or_address_strap,
  input wire logic amp_shutdown_n,
  input wire logic bridge_mode_or_i2c_clock,
  input wire logic switch_rate_or_i2c_data_in,
  input wire logic switch_rate_or_i2c_data_oe,
  input wire logic i2c_sda_pull_low,
  input wire logic i2c_scl_in,
  // settings and state
  input wire gain_cfg_type gain_cfg,
  input wire out_cfg_type out_cfg,
  input wire logic software_mode,
  input wire logic shutdown_active,
  input wire logic signal_path_en,
  input wire logic sleep_active,
  input wire logic output_hiz,
  input wire logic [7:0] drive_level
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // three cycles so a ramp that was still rising has turned round
  sequence asleep;
    sleep_active [*3];
  endsequence
  sequence strap_steady;
    !software_mode [*3];
  endsequence
  AST_SLEEP_TAKE: assert property (
    !software_mode && sleep_or_address_strap && amp_shutdown_n |=> sleep_active)
    else $error("sleep pin ignored");
  AST_RAMP_FALL: assert property (
    asleep ##0 drive_level != 8'h00 |=> drive_level == $past(drive_level) - 8'h01)
    else $error("ramp not falling by one");
  AST_HIZ_AT_ZERO: assert property (
    asleep ##0 drive_level == 8'h00 |=> output_hiz)
    else $error("stage still switching");
  AST_PATH_ALIVE: assert property (
    sleep_or_address_strap && amp_shutdown_n |=> signal_path_en)
    else $error("signal path stopped in sleep");
  AST_SHUTDOWN: assert property (
    1'b1 |=> shutdown_active == !$past(amp_shutdown_n))
    else $error("shutdown pin not followed");
  AST_BOOST_VOL: assert property (
    !software_mode |-> gain_cfg.boost == `BOOST_CODE_6DB
    && gain_cfg.volume == `VOLUME_CODE_0DB)
    else $error("boost or volume moved");
  AST_PIN_SHARE: assert property (
    i2c_scl_in == (software_mode ? bridge_mode_or_i2c_clock : 1'b1)
    && switch_rate_or_i2c_data_oe == (software_mode && i2c_sda_pull_low))
    else $error("shared pins misrouted");
  AST_OUT_CFG: assert property (
    strap_steady |-> out_cfg == {$past(bridge_mode_or_i2c_clock),
    $past(bridge_mode_or_i2c_clock), !$past(switch_rate_or_i2c_data_in)})
    else $error("strap output config wrong");
endmodule : amp_strap_checker

bind amp_strap_control amp_strap_checker amp_strap_checker_inst (
  .mclk(mclk),
  .rst_n(rst_n),
  .sleep_or_address_strap(sleep_or_address_strap),
  .amp_shutdown_n(amp_shutdown_n),
  .bridge_mode_or_i2c_clock(bridge_mode_or_i2c_clock),
  .switch_rate_or_i2c_data_in(switch_rate_or_i2c_data_in),
  .switch_rate_or_i2c_data_oe(switch_rate_or_i2c_data_oe),
  .i2c_sda_pull_low(i2c_sda_pull_low),
  .i2c_scl_in(i2c_scl_in),
  .gain_cfg(gain_cfg),
  .out_cfg(out_cfg),
  .software_mode(software_mode),
  .shutdown_active(shutdown_active),
  .signal_path_en(signal_path_en),
  .sleep_active(sleep_active),
  .output_hiz(output_hiz),
  .drive_level(drive_level)
);

// ==== tb/strap_board_model.sv ====
// board strap and open-drain rate or data line
`timescale 1ns/1ps
module strap_board_model
(
  // strap level and device pull-down
  input wire logic rate_strap,
  input wire logic sda_oe,
  // resolved pin level
  output logic rate_pin
);
  // the strap resistor holds the level unless the device pulls low
  assign rate_pin = sda_oe ? 1'b0 : rate_strap;
endmodule : strap_board_model

// ==== tb/amp_strap_control_tb.sv ====
// self-checking bench for the strap and sleep control
`timescale 1ns/1ps
`include "amp_strap_map.svh"
module amp_strap_control_tb
  import amp_strap_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] gain_strap_pins = 2'h0;
  logic sleep_or_address_strap = 1'b0;
  logic amp_shutdown_n = 1'b1;
  logic bridge_mode_or_i2c_clock = 1'b0;
  logic rate_strap = 1'b0;
  logic i2c_sda_pull_low = 1'b0;
  logic sw_sleep = 1'b0;
  logic sw_balanced_mute = 1'b1;
  gain_cfg_type sw_gain_cfg = 12'ha40;
  out_cfg_type sw_out_cfg = 3'h5;
  gain_cfg_type gain_cfg;
  out_cfg_type out_cfg;
  logic [7:0] drive_level;
  logic switch_rate_or_i2c_data_in, switch_rate_or_i2c_data_out, switch_rate_or_i2c_data_oe;
  logic i2c_enable, i2c_scl_in, i2c_sda_in, software_mode, balanced_mute;
  logic shutdown_active, signal_path_en, sleep_active, switching_en, output_hiz;
  int miscompares = 0;
  int num_checks = 0;
  int n;
  logic [11:0] exp_gain;
  // gain straps, rate, bridge, expected analog gain, spare, expected out_cfg
  logic [9:0] rows [3] = '{10'h001, 10'h190, 10'h26f};

  always #20 mclk = ~mclk;

  strap_board_model strap_board_model_inst (
    .rate_strap(rate_strap),
    .sda_oe(switch_rate_or_i2c_data_oe),
    .rate_pin(switch_rate_or_i2c_data_in)
  );
  amp_strap_control amp_strap_control_inst (
    .mclk(mclk),
    .rst_n(rst_n),
    .gain_strap_pins(gain_strap_pins),
    .sleep_or_address_strap(sleep_or_address_strap),
    .amp_shutdown_n(amp_shutdown_n),
    .bridge_mode_or_i2c_clock(bridge_mode_or_i2c_clock),
    .switch_rate_or_i2c_data_in(switch_rate_or_i2c_data_in),
    .switch_rate_or_i2c_data_out(switch_rate_or_i2c_data_out),
    .switch_rate_or_i2c_data_oe(switch_rate_or_i2c_data_oe),
    .i2c_enable(i2c_enable),
    .i2c_scl_in(i2c_scl_in),
    .i2c_sda_in(i2c_sda_in),
    .i2c_sda_pull_low(i2c_sda_pull_low),
    .sw_gain_cfg(sw_gain_cfg),
    .sw_out_cfg(sw_out_cfg),
    .sw_sleep(sw_sleep),
    .sw_balanced_mute(sw_balanced_mute),
    .gain_cfg(gain_cfg),
    .out_cfg(out_cfg),
    .software_mode(software_mode),
    .balanced_mute(balanced_mute),
    .shutdown_active(shutdown_active),
    .signal_path_en(signal_path_en),
    .sleep_active(sleep_active),
    .switching_en(switching_en),
    .output_hiz(output_hiz),
    .drive_level(drive_level)
  );

  task automatic step(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : step

  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic boot();
    rst_n = 1'b0;
    step(8);
    rst_n = 1'b1;
    step(3);
  endtask : boot

  task automatic close_out();
    if (miscompares == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  initial
  begin
    foreach (rows[i])
    begin
      {gain_strap_pins, rate_strap, bridge_mode_or_i2c_clock} = rows[i][9:6];
      exp_gain = {rows[i][5:4], `BOOST_CODE_6DB, `VOLUME_CODE_0DB};
      boot();
      chk("gain", gain_cfg, exp_gain);
      chk("out", out_cfg, rows[i][2:0]);
      chk("mode", software_mode, 1'b0);
      chk("i2c idle", {i2c_enable, i2c_scl_in, i2c_sda_in, balanced_mute}, 4'h6);
      gain_strap_pins = 2'h3;
      step(3);
      chk("gain held", gain_cfg, exp_gain);
    end
    step(260);
    chk("level", {switching_en, drive_level}, 9'h1fa);
    sleep_or_address_strap = 1'b1;
    step(2);
    chk("asleep", {sleep_active, signal_path_en}, 2'h3);
    n = 0;
    while (n < 300 && output_hiz !== 1'b1)
    begin
      step(1);
      n++;
    end
    chk("stage", {output_hiz, switching_en, drive_level}, 10'h200);
    chk("graceful", n >= 248, 1'b1);
    // sleep is already up before shutdown, as the controller should do
    amp_shutdown_n = 1'b0;
    step(2);
    chk("shutdown", {shutdown_active, signal_path_en, sleep_active}, 3'h4);
    amp_shutdown_n = 1'b1;
    step(2);
    chk("wake", shutdown_active, 1'b0);
    {gain_strap_pins, rate_strap, bridge_mode_or_i2c_clock} = 4'hf;
    sleep_or_address_strap = 1'b0;
    boot();
    chk("sw gain", gain_cfg, sw_gain_cfg);
    chk("sw mode", {software_mode, i2c_enable}, 2'h3);
    chk("sw out", out_cfg, sw_out_cfg);
    chk("sda out", switch_rate_or_i2c_data_out, 1'b0);
    bridge_mode_or_i2c_clock = 1'b0;
    i2c_sda_pull_low = 1'b1;
    #1;
    chk("i2c pins", {i2c_scl_in, i2c_sda_in, switch_rate_or_i2c_data_oe}, 3'h1);
    step(260);
    chk("mute", {balanced_mute, switching_en}, 2'h3);
    sleep_or_address_strap = 1'b1;
    step(2);
    chk("adr strap", sleep_active, 1'b0);
    sw_sleep = 1'b1;
    step(2);
    chk("sw sleep", {sleep_active, balanced_mute, signal_path_en}, 3'h7);
    close_out();
  end

  // about three times the expected run length
  initial
  begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule : amp_strap_control_tb
